/* spi_cmd_consts.svh */
`ifndef SPI_CMD_CONSTS_SVH
`define SPI_CMD_CONSTS_SVH
// Frame length and bit counter
`define FRAME_BITS      5'h10
`define CNT_MAX         5'h1F
// Watchdog and prescaler commands
`define CMD_WD_TRIGGER  16'h6A55
`define PRESC_HI        8'h60
`define PRESC_LO_TOP    5'h1E
`define PRESC_RST       3'h0
// Switch commands
`define CMD_BOOST_ENABLE 16'h9A5A
`define CMD_BOOST_33    16'h930F
`define CMD_BOOST_23    16'h93F0
`define CMD_BOOST_EXT   16'h9396
`define CMD_CPO_HIGH    16'h960F
`define CMD_CPO_LOW     16'h96F0
`define CMD_LP1_ISO     16'h99F0
`define CMD_LP1_LS      16'h99FF
`define CMD_LP2_ISO     16'h9900
`define CMD_LP2_LS      16'h990F
`define KSW_HI          8'h9C
`define LP1_HIZ         8'hF0
`define LP1_LOZ         8'hFF
`define LP2_HIZ         8'h00
`define LP2_LOZ         8'h0F
// Programming register write
`define IP_WRITE_HI     8'hA9
`define IP_RST          8'h00
// Diagnosis commands
`define CMD_DIAG_OFF    16'hC000
`define DIAG_HI         8'hCA
`define DIAG_BOOST      8'h31
`define DIAG_SAT        8'h32
`define DIAG_PERI90     8'h34
`define DIAG_PERI10     8'h38
`define DIAG_CORE       8'h61
`define DIAG_IGN        8'h62
`define DIAG_BATT       8'h64
`define DIAG_IREF       8'h68
`define DIAG_SRC1       8'h92
`define DIAG_SRC2       8'h94
`define DIAG_SRC3       8'h98
`define DIAG_SRC4       8'hC1
`define DIAG_SRC5       8'hC2
`define DIAG_CMP        8'hC4
`define DIAG_LP1        8'hC8
`define DIAG_LP2        8'hE1
`define DIAG_INT_SUPPLY 8'hE2
`define DIAG_CHIP_TEMP  8'hE4
`define DIAG_NONE       8'h00
// Current source commands
`define ISRC_TOP        5'h1E
`define ISRC_10V_10     8'h33
`define ISRC_10V_15     8'h3C
`define ISRC_5V_10      8'hC3
`define ISRC_5V_15      8'hCC
`define SRC_MIN         3'h1
`define SRC_MAX         3'h5
// Test mode words and answers
`define CMD_TM1         16'h55AA
`define CMD_TM2         16'hAA55
`define CMD_TM3         16'h5500
`define CMD_TM_ENTER    16'h5A5A
`define CMD_SUP1        16'hE6B5
`define CMD_SUP2        16'hE6BA
`define ANS_TM3_HI      8'h01
`endif

/* spi_cmd_pkg.sv */
`default_nettype none
package spi_cmd_pkg;
	// Link framing state
	typedef enum logic [0:0] {LINK_IDLE, LINK_FRAME} link_state_t;
	// Boost converter setting
	typedef enum logic [1:0] {BOOST_23V, BOOST_33V, BOOST_EXT} boost_t;
endpackage : spi_cmd_pkg
`default_nettype wire

/* spi_command_status.sv */
// Behaviour
// - CAE2 routes internal supply, CAE4 chip temperature
// - Diagnosis ends on next command, except 6A55/9Cxx
// - Current source lower byte selects voltage and mirror
// - Source index one to five only valid
// - Current source ends on next command, except 6A55/9Cxx
// - Status word answered except after test words
// - Status is 16 bits, byte A then B
// - a7..a5 report chip and line port overtemperature
// - Overtemperature bits latch, clear on command if gone
// - a4 reports key latch function
// - a3 high for 33V or external divider
// - a2 high when pump output switch low impedance
// - a1 pump output low, a0 charge pump low
// - b7 comparator above threshold, b6 ground open
// - b5 previous command invalid, power-on high
// - b4 last transfer error, power-on high
// - Ordinary reset keeps b4 and b5
// - b3 test mode, b2..b0 watchdog prescaler
// - Test words answer AA55, 55AA, 01 plus register
// - Test entry needs pin levels and 5A5A
// - Test mode latched until any reset
// - Test mode disables watchdog, resets follow rails
// - Test mode and unlocked drives 12.5V saturation rail
`include "spi_cmd_consts.svh"
`default_nettype none
module spi_command_status (
	// Clock and resets
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire logic                 por,
	// Serial link pins
	input  wire logic                 sclk,
	input  wire logic                 cs_n,
	input  wire logic                 mosi,
	output logic                      miso,
	output logic                      miso_oe,
	// Pin levels sensed for test entry
	input  wire logic                 reset_out_primary_pin,
	input  wire logic                 reset_out_secondary_pin,
	input  wire logic                 transmit_in_one,
	input  wire logic                 transmit_in_two,
	// Analog status inputs
	input  wire logic                 chip_overtemp,
	input  wire logic                 line_port_one_overtemp,
	input  wire logic                 line_port_two_overtemp,
	input  wire logic                 key_latch_function,
	input  wire logic                 pump_output_low,
	input  wire logic                 charge_pump_level_low,
	input  wire logic                 general_comparator_input,
	input  wire logic                 analog_ground_a_open,
	input  wire logic                 analog_ground_b_open,
	input  wire logic                 rails_ok,
	input  wire logic                 watchdog_expired,
	input  wire logic                 prog_lock,
	// Diagnosis and current source controls
	output logic [7:0]                analog_selector,
	output logic                      diag_active,
	output logic [2:0]                current_sense_source,
	output logic [7:0]                source_setting,
	output logic                      source_active,
	// Supply and line port controls
	output logic [2:0]                prescaler,
	output spi_cmd_pkg::boost_t       boost_converter,
	output logic                      pump_output_switch,
	output logic                      line_port_one_ls,
	output logic                      line_port_two_ls,
	output logic                      line_port_one_low_imp,
	output logic                      line_port_two_low_imp,
	output logic [7:0]                ip_register,
	// Test mode and reset outputs
	output logic                      test_mode,
	output logic                      watchdog_disable,
	output logic                      sat_rail_12v5,
	output logic                      reset_out_primary_n,
	output logic                      reset_out_secondary_n
);
	import spi_cmd_pkg::*;

	localparam int SW = 19;            // Synchronised input count

	logic [SW-1:0] pins;               // Raw pin vector
	logic [SW-1:0] s1_r;               // First sync stage
	logic [SW-1:0] s2_r;               // Second sync stage
	logic          sclk_d_r;           // Previous clock level
	logic          cs_d_r;             // Previous select level
	logic          sclk_s, cs_s, mosi_s;
	logic          rpri_s, rsec_s, tx1_s, tx2_s;
	logic [2:0]    ot_now;             // Live overtemperature levels
	logic          key_s, pump_low_s, lvl_low_s, cmp_s, gnd_open_s;
	logic          rails_s, wd_exp_s, lock_s;

	link_state_t   state_r, state_nxt; // Framing state
	logic [4:0]    cnt_r, cnt_nxt;     // Bits received
	logic [15:0]   rx_r, rx_nxt;       // Incoming command
	logic [15:0]   tx_r, tx_nxt;       // Outgoing answer
	logic          miso_r, miso_nxt;
	logic          echo_r, echo_nxt;   // Next answer is an echo
	logic [15:0]   echo_w_r, echo_w_nxt;
	logic [2:0]    ot_r, ot_nxt;       // Latched overtemperature
	logic [7:0]    sel_r, sel_nxt;
	logic          diag_r, diag_nxt;
	logic [2:0]    src_r, src_nxt;
	logic [7:0]    set_r, set_nxt;
	logic          srca_r, srca_nxt;
	logic [2:0]    presc_r, presc_nxt;
	boost_t        boost_r, boost_nxt;
	logic          cpo_r, cpo_nxt;
	logic          k1ls_r, k1ls_nxt, k2ls_r, k2ls_nxt;
	logic          k1lo_r, k1lo_nxt, k2lo_r, k2lo_nxt;
	logic [7:0]    ip_r, ip_nxt;
	logic          tm_r, tm_nxt;
	logic          rpo_r, rpo_nxt;     // Reset output level
	logic          inv_r, inv_nxt;     // Power-on domain flags
	logic          err_r, err_nxt;

	logic          sclk_rise, sclk_fall, cs_fall, cs_rise;
	logic          frame_done;         // Select released
	logic          frame_ok;           // Exactly sixteen bits
	logic          cmd_valid;          // Decoded as a known command
	logic [15:0]   status_word;
	logic [15:0]   answer;

	// All outside levels pass two flops first
	assign pins = {sclk, cs_n, mosi, reset_out_primary_pin,
		reset_out_secondary_pin, transmit_in_one, transmit_in_two,
		chip_overtemp, line_port_one_overtemp, line_port_two_overtemp,
		key_latch_function, pump_output_low, charge_pump_level_low,
		general_comparator_input, analog_ground_a_open,
		analog_ground_b_open, rails_ok, watchdog_expired, prog_lock};

	// Synchroniser chain plus edge history
	always_ff @(posedge clock or posedge rst or posedge por) begin
		if (rst || por) begin
			s1_r     <= 19'h20000;     // Select bit idles high
			s2_r     <= 19'h20000;     // So reset leaves no false edge
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b1;
		end else begin
			s1_r     <= pins;
			s2_r     <= s1_r;
			sclk_d_r <= sclk_s;
			cs_d_r   <= cs_s;
		end
	end

	// Unpack synchronised levels
	assign {sclk_s, cs_s, mosi_s, rpri_s, rsec_s, tx1_s, tx2_s} = s2_r[18:12];
	assign ot_now = s2_r[11:9];
	assign {key_s, pump_low_s, lvl_low_s, cmp_s} = s2_r[8:5];
	assign gnd_open_s = s2_r[4] | s2_r[3];
	assign {rails_s, wd_exp_s, lock_s} = s2_r[2:0];

	// Edges of the sampled link clock and select
	assign sclk_rise  = sclk_s & ~sclk_d_r;
	assign sclk_fall  = ~sclk_s & sclk_d_r;
	assign cs_fall    = ~cs_s & cs_d_r;
	assign cs_rise    = cs_s & ~cs_d_r;
	assign frame_done = (state_r == LINK_FRAME) && cs_rise;
	assign frame_ok   = (cnt_r == `FRAME_BITS);

	// Status word, byte A high, byte B low
	assign status_word = {ot_r, key_s, boost_r != BOOST_23V, cpo_r,
		pump_low_s, lvl_low_s, cmp_s, gnd_open_s,
		inv_r, err_r, tm_r, presc_r};
	// Echo replaces status only after a test word
	assign answer = echo_r ? echo_w_r : status_word;

	// Next state of link, decoder and controls
	always_comb begin
		logic [7:0] hi;
		logic [7:0] lo;
		logic       ends;
		hi         = rx_r[15:8];
		lo         = rx_r[7:0];
		ends       = 1'b1;
		cmd_valid  = 1'b0;
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		rx_nxt     = rx_r;
		tx_nxt     = tx_r;
		miso_nxt   = miso_r;
		echo_nxt   = echo_r;
		echo_w_nxt = echo_w_r;
		ot_nxt     = ot_r | ot_now;
		sel_nxt    = sel_r;
		diag_nxt   = diag_r;
		src_nxt    = src_r;
		set_nxt    = set_r;
		srca_nxt   = srca_r;
		presc_nxt  = presc_r;
		boost_nxt  = boost_r;
		cpo_nxt    = cpo_r;
		k1ls_nxt   = k1ls_r;
		k2ls_nxt   = k2ls_r;
		k1lo_nxt   = k1lo_r;
		k2lo_nxt   = k2lo_r;
		ip_nxt     = ip_r;
		tm_nxt     = tm_r;
		// Watchdog ignored in test mode
		rpo_nxt    = rails_s & (tm_r | ~wd_exp_s);
		case (state_r)
			LINK_IDLE: begin
				// First answer bit must stand before the first rise
				if (cs_fall) begin
					state_nxt = LINK_FRAME;
					cnt_nxt   = 5'h00;
					tx_nxt    = answer;
					miso_nxt  = answer[15];
				end
			end
			LINK_FRAME: begin
				if (cs_rise) begin
					state_nxt = LINK_IDLE;
				end else begin
					// Sample on rise, shift on fall, MSB first
					if (sclk_rise) begin
						rx_nxt = {rx_r[14:0], mosi_s};
						if (cnt_r != `CNT_MAX) begin
							cnt_nxt = cnt_r + 5'h01;
						end
					end
					if (sclk_fall) begin
						tx_nxt   = {tx_r[14:0], 1'b0};
						miso_nxt = tx_r[14];
					end
				end
			end
			default: begin
				state_nxt = LINK_IDLE;
			end
		endcase
		// Only complete sixteen bit frames execute
		if (frame_done && frame_ok) begin
			echo_nxt = 1'b0;
			ot_nxt   = ot_now;
			if (rx_r == `CMD_WD_TRIGGER) begin
				cmd_valid = 1'b1;
				ends      = 1'b0;
			end else if (hi == `KSW_HI) begin
				ends = 1'b0;
				// Line port switching only legal in driver mode
				if (k1ls_r && (lo == `LP1_HIZ || lo == `LP1_LOZ)) begin
					cmd_valid = 1'b1;
					k1lo_nxt  = (lo == `LP1_LOZ);
				end else if (k2ls_r && (lo == `LP2_HIZ || lo == `LP2_LOZ)) begin
					cmd_valid = 1'b1;
					k2lo_nxt  = (lo == `LP2_LOZ);
				end
			end
			// Any other command ends the non-latching functions
			if (ends) begin
				diag_nxt = 1'b0;
				srca_nxt = 1'b0;
			end
			if (hi == `PRESC_HI && lo[7:3] == `PRESC_LO_TOP) begin
				cmd_valid = 1'b1;
				presc_nxt = lo[2:0];
			end else if (hi == `IP_WRITE_HI && tm_r) begin
				cmd_valid = 1'b1;
				ip_nxt    = lo;
			end else if (hi == `DIAG_HI) begin
				case (lo)
					`DIAG_BOOST, `DIAG_SAT, `DIAG_PERI90, `DIAG_PERI10,
					`DIAG_CORE, `DIAG_IGN, `DIAG_BATT, `DIAG_IREF,
					`DIAG_SRC1, `DIAG_SRC2, `DIAG_SRC3, `DIAG_SRC4,
					`DIAG_SRC5, `DIAG_CMP, `DIAG_LP1, `DIAG_LP2,
					`DIAG_INT_SUPPLY, `DIAG_CHIP_TEMP: begin
						cmd_valid = 1'b1;
						sel_nxt   = lo;
						diag_nxt  = 1'b1;
					end
					default: begin
						cmd_valid = 1'b0;
					end
				endcase
			end else if (hi[7:3] == `ISRC_TOP) begin
				// Index outside one to five is refused
				if (hi[2:0] >= `SRC_MIN && hi[2:0] <= `SRC_MAX &&
					(lo == `ISRC_10V_10 || lo == `ISRC_10V_15 ||
					lo == `ISRC_5V_10 || lo == `ISRC_5V_15)) begin
					cmd_valid = 1'b1;
					src_nxt   = hi[2:0];
					set_nxt   = lo;
					srca_nxt  = 1'b1;
				end
			end else begin
				case (rx_r)
					`CMD_BOOST_ENABLE, `CMD_SUP1, `CMD_SUP2: cmd_valid = 1'b1;
					`CMD_BOOST_33: begin
						cmd_valid = 1'b1;
						boost_nxt = BOOST_33V;
					end
					`CMD_BOOST_23: begin
						cmd_valid = 1'b1;
						boost_nxt = BOOST_23V;
					end
					`CMD_BOOST_EXT: begin
						cmd_valid = 1'b1;
						boost_nxt = BOOST_EXT;
					end
					`CMD_CPO_HIGH, `CMD_CPO_LOW: begin
						cmd_valid = 1'b1;
						cpo_nxt   = (rx_r == `CMD_CPO_LOW);
					end
					`CMD_LP1_ISO, `CMD_LP1_LS: begin
						cmd_valid = 1'b1;
						k1ls_nxt  = (rx_r == `CMD_LP1_LS);
					end
					`CMD_LP2_ISO, `CMD_LP2_LS: begin
						cmd_valid = 1'b1;
						k2ls_nxt  = (rx_r == `CMD_LP2_LS);
					end
					`CMD_DIAG_OFF: begin
						cmd_valid = 1'b1;
						sel_nxt   = `DIAG_NONE;
					end
					`CMD_TM1: begin
						cmd_valid  = 1'b1;
						echo_nxt   = 1'b1;
						echo_w_nxt = `CMD_TM2;
					end
					`CMD_TM2: begin
						cmd_valid  = 1'b1;
						echo_nxt   = 1'b1;
						echo_w_nxt = `CMD_TM1;
					end
					`CMD_TM3: begin
						cmd_valid  = 1'b1;
						echo_nxt   = 1'b1;
						echo_w_nxt = {`ANS_TM3_HI, ip_r};
					end
					`CMD_TM_ENTER: begin
						cmd_valid = 1'b1;
						// Pins low, low, high, high before entry
						if (!rpri_s && !tx1_s && rsec_s && tx2_s) begin
							tm_nxt = 1'b1;
						end
					end
					default: begin
						cmd_valid = cmd_valid;
					end
				endcase
			end
		end
	end

	// Registers cleared by either reset
	always_ff @(posedge clock or posedge rst or posedge por) begin
		if (rst || por) begin
			state_r  <= LINK_IDLE;
			cnt_r    <= 5'h00;
			rx_r     <= 16'h0000;
			tx_r     <= 16'h0000;
			miso_r   <= 1'b0;
			echo_r   <= 1'b0;
			echo_w_r <= 16'h0000;
			ot_r     <= 3'h0;
			sel_r    <= `DIAG_NONE;
			diag_r   <= 1'b0;
			src_r    <= 3'h0;
			set_r    <= 8'h00;
			srca_r   <= 1'b0;
			presc_r  <= `PRESC_RST;
			boost_r  <= BOOST_23V;
			cpo_r    <= 1'b0;
			k1ls_r   <= 1'b0;
			k2ls_r   <= 1'b0;
			k1lo_r   <= 1'b0;
			k2lo_r   <= 1'b0;
			ip_r     <= `IP_RST;
			tm_r     <= 1'b0;
			rpo_r    <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			rx_r     <= rx_nxt;
			tx_r     <= tx_nxt;
			miso_r   <= miso_nxt;
			echo_r   <= echo_nxt;
			echo_w_r <= echo_w_nxt;
			ot_r     <= ot_nxt;
			sel_r    <= sel_nxt;
			diag_r   <= diag_nxt;
			src_r    <= src_nxt;
			set_r    <= set_nxt;
			srca_r   <= srca_nxt;
			presc_r  <= presc_nxt;
			boost_r  <= boost_nxt;
			cpo_r    <= cpo_nxt;
			k1ls_r   <= k1ls_nxt;
			k2ls_r   <= k2ls_nxt;
			k1lo_r   <= k1lo_nxt;
			k2lo_r   <= k2lo_nxt;
			ip_r     <= ip_nxt;
			tm_r     <= tm_nxt;
			rpo_r    <= rpo_nxt;
		end
	end

	// Framing flags: only complete frames touch invalid
	always_comb begin
		inv_nxt = inv_r;
		err_nxt = err_r;
		if (frame_done) begin
			err_nxt = ~frame_ok;
			if (frame_ok) begin
				inv_nxt = ~cmd_valid;
			end
		end
	end

	// Power-on only, so ordinary reset keeps them
	always_ff @(posedge clock or posedge por) begin
		if (por) begin
			inv_r <= 1'b1;
			err_r <= 1'b1;
		end else begin
			inv_r <= inv_nxt;
			err_r <= err_nxt;
		end
	end

	// Output assignments
	assign miso                  = miso_r;
	assign miso_oe               = (state_r == LINK_FRAME);
	assign analog_selector       = diag_r ? sel_r : `DIAG_NONE;
	assign diag_active           = diag_r;
	assign current_sense_source  = src_r;
	assign source_setting        = set_r;
	assign source_active         = srca_r;
	assign prescaler             = presc_r;
	assign boost_converter       = boost_r;
	assign pump_output_switch    = cpo_r;
	assign line_port_one_ls      = k1ls_r;
	assign line_port_two_ls      = k2ls_r;
	assign line_port_one_low_imp = k1lo_r;
	assign line_port_two_low_imp = k2lo_r;
	assign ip_register           = ip_r;
	assign test_mode             = tm_r;
	assign watchdog_disable      = tm_r;
	assign sat_rail_12v5         = tm_r & ~lock_s;
	assign reset_out_primary_n   = rpo_r;
	assign reset_out_secondary_n = rpo_r;
endmodule : spi_command_status
`default_nettype wire

/* spi_host_model.sv */
`default_nettype none
module spi_host_model (
	// Link pins towards the device
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;
	// Half of the 125 ns link period
	localparam real HALF = 62.5;

	// Link clock parked low, select idle outside frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end

	// One frame; fewer than 16 bits gives a broken frame
	task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] ans);
		ans = 16'h0000;
		// Step off the system clock edge so no pin races it
		#1;
		cs_n = 1'b0;
		for (int i = 15; i > 15 - nbits; i--) begin
			mosi = cmd[i];
			#HALF;
			sclk = 1'b1;
			ans = {ans[14:0], miso};
			#HALF;
			sclk = 1'b0;
		end
		#HALF;
		cs_n = 1'b1;
		// Released line must not keep the last bit
		mosi = ~mosi;
		#400;
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* spi_command_status_asserts.sv */
`default_nettype none
module spi_command_status_asserts (
	// Clock and resets
	input wire logic       clock,
	input wire logic       rst,
	input wire logic       por,
	// Link and sensed levels
	input wire logic       cs_n,
	input wire logic       miso_oe,
	input wire logic       rails_ok,
	input wire logic       prog_lock,
	// Device controls
	input wire logic [7:0] analog_selector,
	input wire logic       diag_active,
	input wire logic       source_active,
	input wire logic       test_mode,
	input wire logic       watchdog_disable,
	input wire logic       sat_rail_12v5,
	input wire logic       reset_out_primary_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst || por);

	// Watchdog off exactly while testing
	chk_wd_follow: assert property (watchdog_disable == test_mode)
		else $error("watchdog disable wrong");
	// Programming rail up when testing and unlocked
	chk_rail_on: assert property ((test_mode && !prog_lock)[*4] |-> sat_rail_12v5)
		else $error("rail not raised");
	// Lock forces the rail down, sync lag allowed
	chk_rail_off: assert property (prog_lock[*5] |-> !sat_rail_12v5)
		else $error("rail raised while locked");
	// Bad rails always pull reset
	chk_reset_rails: assert property (!rails_ok[*4] |-> !reset_out_primary_n)
		else $error("reset not asserted");
	// In test mode only the rails decide
	chk_test_rails: assert property ((test_mode && rails_ok)[*5] |-> reset_out_primary_n)
		else $error("reset asserted in test mode");
	// Test mode sticks until a reset
	chk_mode_kept: assert property (test_mode |=> test_mode)
		else $error("test mode dropped");
	// A new function ends the other one
	chk_one_function: assert property (!(diag_active && source_active))
		else $error("diagnosis and source together");
	// Nothing executes in the middle of a frame
	chk_frame_hold: assert property (!cs_n[*8] |-> $stable(analog_selector) && $stable(diag_active))
		else $error("control moved mid frame");
	// Answer driven while selected
	chk_oe_open: assert property (!cs_n[*5] |-> miso_oe)
		else $error("answer not driven");

	cov_entry: cover property ($rose(test_mode));
	cov_diag: cover property ($rose(diag_active));
	cov_source: cover property ($rose(source_active));
endmodule : spi_command_status_asserts

bind spi_command_status spi_command_status_asserts chk_i (.clock, .rst, .por, .cs_n,
	.miso_oe, .rails_ok, .prog_lock, .analog_selector, .diag_active, .source_active,
	.test_mode, .watchdog_disable, .sat_rail_12v5, .reset_out_primary_n);
`default_nettype wire

/* spi_command_status_testmode_tb_top.sv */
`default_nettype none
module spi_command_status_testmode_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import spi_cmd_pkg::*;
	// Clock, resets and link
	logic clock = 1'b0, rst = 1'b0, por = 1'b1;
	logic sclk, cs_n, mosi, miso, miso_oe;
	// Levels sensed for test entry, entry pattern off
	logic reset_out_primary_pin = 1'b1, reset_out_secondary_pin = 1'b0;
	logic transmit_in_one = 1'b1, transmit_in_two = 1'b0;
	// Analog status levels
	logic chip_overtemp = 1'b0, line_port_one_overtemp = 1'b0;
	logic line_port_two_overtemp = 1'b0, key_latch_function = 1'b0;
	logic pump_output_low = 1'b0, charge_pump_level_low = 1'b0;
	logic general_comparator_input = 1'b0, analog_ground_a_open = 1'b0;
	logic analog_ground_b_open = 1'b0, rails_ok = 1'b1;
	logic watchdog_expired = 1'b0, prog_lock = 1'b0;
	// Device controls
	logic [7:0] analog_selector, source_setting, ip_register;
	logic [2:0] current_sense_source, prescaler;
	boost_t     boost_converter;
	logic       diag_active, source_active, pump_output_switch;
	logic       line_port_one_ls, line_port_two_ls;
	logic       line_port_one_low_imp, line_port_two_low_imp;
	logic       test_mode, watchdog_disable, sat_rail_12v5;
	logic       reset_out_primary_n, reset_out_secondary_n;
	// Score keeping and answer of the last frame
	int          err_total = 0, check_count = 0, cycles = 0;
	logic [15:0] ans;
	logic [7:0]  srcb [4] = '{8'h33, 8'h3C, 8'hC3, 8'hCC};

	spi_host_model host (.sclk, .cs_n, .mosi, .miso);

	spi_command_status dut (.clock, .rst, .por, .sclk, .cs_n, .mosi, .miso, .miso_oe,
		.reset_out_primary_pin, .reset_out_secondary_pin, .transmit_in_one,
		.transmit_in_two, .chip_overtemp, .line_port_one_overtemp,
		.line_port_two_overtemp, .key_latch_function, .pump_output_low,
		.charge_pump_level_low, .general_comparator_input, .analog_ground_a_open,
		.analog_ground_b_open, .rails_ok, .watchdog_expired, .prog_lock,
		.analog_selector, .diag_active, .current_sense_source, .source_setting,
		.source_active, .prescaler, .boost_converter, .pump_output_switch,
		.line_port_one_ls, .line_port_two_ls, .line_port_one_low_imp,
		.line_port_two_low_imp, .ip_register, .test_mode, .watchdog_disable,
		.sat_rail_12v5, .reset_out_primary_n, .reset_out_secondary_n);

	// 100 MHz system clock
	always #5 clock = ~clock;

	// Hang guard, about three times the expected run
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_total++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Settle synced levels, then one frame and its answer
	task automatic frame(input logic [15:0] c, input logic [15:0] e);
		repeat (4) @(posedge clock);
		host.xfer(c, 16, ans);
		chk(ans, e);
	endtask : frame

	// Ordinary reset pulse
	task automatic pulse_rst();
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : pulse_rst

	initial begin
		repeat (6) @(posedge clock);
		por <= 1'b0;
		// Power-on flags, then diagnosis routing
		frame(16'hCAE2, 16'h0030);
		chk(16'(analog_selector), 16'h00E2);
		frame(16'h6A55, 16'h0000);
		chk(16'(diag_active), 16'h0001);
		frame(16'hCAE4, 16'h0000);
		chk(16'(analog_selector), 16'h00E4);
		$display("test diag done");
		// Every source index and every setting
		for (int i = 1; i <= 5; i++) begin
			frame({5'h1E, 3'(i), srcb[i % 4]}, 16'h0000);
			chk({14'h0, diag_active, source_active}, 16'h0001);
			chk({13'h0, current_sense_source}, 16'(i));
			chk(16'(source_setting), 16'(srcb[i % 4]));
		end
		frame(16'h6A55, 16'h0000);
		frame(16'h9CFF, 16'h0000);
		chk(16'(source_active), 16'h0001);
		frame(16'hF033, 16'h0020);
		chk(16'(source_active), 16'h0000);
		frame(16'hF633, 16'h0020);
		frame(16'h930F, 16'h0020);
		frame(16'h96F0, 16'h0800);
		frame(16'h60F5, 16'h0C00);
		frame(16'h6A55, 16'h0C05);
		$display("test source done");
		// Live status levels
		@(posedge clock);
		{key_latch_function, pump_output_low, charge_pump_level_low} <= 3'h7;
		{general_comparator_input, analog_ground_b_open} <= 2'h3;
		frame(16'h6A55, 16'h1FC5);
		@(posedge clock);
		{key_latch_function, pump_output_low, charge_pump_level_low} <= 3'h0;
		{general_comparator_input, analog_ground_b_open} <= 2'h0;
		// Short overheat pulse latches; a lasting one survives a command
		{chip_overtemp, line_port_one_overtemp, line_port_two_overtemp} <= 3'h7;
		repeat (8) @(posedge clock);
		{chip_overtemp, line_port_one_overtemp} <= 2'h0;
		frame(16'h6A55, 16'hEC05);
		@(posedge clock);
		line_port_two_overtemp <= 1'b0;
		frame(16'h6A55, 16'h2C05);
		frame(16'h6A55, 16'h0C05);
		$display("test status done");
		// Broken frames set b4 and keep b5; ordinary reset keeps both flags
		host.xfer(16'h6A55, 8, ans);
		frame(16'h9CFF, 16'h0C15);
		host.xfer(16'h6A55, 8, ans);
		pulse_rst();
		frame(16'h6A55, 16'h0030);
		chk(16'(boost_converter), 16'(BOOST_23V));
		$display("test reset done");
		// External divider, line ports in driver mode; 9Cxx keeps diagnosis
		frame(16'h9396, 16'h0000);
		chk(16'(boost_converter), 16'(BOOST_EXT));
		frame(16'h99FF, 16'h0800);
		frame(16'h990F, 16'h0800);
		frame(16'hCAC8, 16'h0800);
		frame(16'h9CFF, 16'h0800);
		frame(16'h9C0F, 16'h0800);
		chk({13'h0, diag_active, line_port_one_ls, line_port_one_low_imp}, 16'h0007);
		chk({14'h0, line_port_two_ls, line_port_two_low_imp}, 16'h0003);
		frame(16'h93F0, 16'h0800);
		$display("test ports done");
		// Entry refused with wrong pins, then accepted
		frame(16'h5A5A, 16'h0000);
		chk(16'(test_mode), 16'h0000);
		@(posedge clock);
		{reset_out_primary_pin, transmit_in_one} <= 2'h0;
		{reset_out_secondary_pin, transmit_in_two, watchdog_expired} <= 3'h7;
		frame(16'h5A5A, 16'h0000);
		chk({13'h0, test_mode, watchdog_disable, sat_rail_12v5}, 16'h0007);
		chk({14'h0, reset_out_primary_n, reset_out_secondary_n}, 16'h0003);
		frame(16'hA95C, 16'h0008);
		chk(16'(ip_register), 16'h005C);
		frame(16'h55AA, 16'h0008);
		frame(16'hAA55, 16'hAA55);
		frame(16'h5500, 16'h55AA);
		frame(16'h6A55, 16'h015C);
		// Lock and failing rails
		@(posedge clock);
		prog_lock <= 1'b1;
		rails_ok <= 1'b0;
		repeat (6) @(posedge clock);
		chk({13'h0, sat_rail_12v5, reset_out_primary_n, reset_out_secondary_n}, 16'h0000);
		pulse_rst();
		chk(16'(test_mode), 16'h0000);
		$display("test mode done");
		results();
	end
endmodule : spi_command_status_testmode_tb_top
`default_nettype wire
